/* File: logic/icl_pkg.sv */
package icl_pkg;
    // control byte layout
    localparam int CTL_GIE_BIT   = 7;
    localparam int CTL_PEIE_BIT  = 6;
    localparam int CTL_TZIE_BIT  = 5;
    localparam int CTL_EXIE_BIT  = 4;
    localparam int CTL_CHIE_BIT  = 3;
    localparam int CTL_TZIF_BIT  = 2;
    localparam int CTL_EXIF_BIT  = 1;
    localparam int CTL_CHIF_BIT  = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // peripheral flag/enable layout
    localparam int PF_ADC_BIT    = 6;
    localparam logic [7:0] PF_RESET  = 8'h00;
    localparam logic [7:0] PF_IMPL   = 8'h40;
    localparam logic [7:0] PF2_IMPL  = 8'h00;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_CTL   = 4'h0;
    localparam logic [3:0] OFS_PFA   = 4'h1;
    localparam logic [3:0] OFS_PFB   = 4'h2;
    localparam logic [3:0] OFS_PEA   = 4'h3;
    localparam logic [3:0] OFS_PEB   = 4'h4;
    localparam logic [3:0] OFS_STAT  = 4'h5;
    localparam logic [3:0] OFS_MASK  = 4'h6;
    // vector and latency
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
    localparam int          SYNC_CYCLES  = 2;
    // sticky event status bits
    localparam int EV_TAKEN_BIT  = 0;
    localparam int EV_RETURN_BIT = 1;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } icl_bus_t;

    typedef struct packed {
        logic        vector;
        logic        push;
        logic [12:0] pc;
    } icl_vec_t;
endpackage

/* File: logic/icl_interrupt_control_logic.sv */
// How it works
// - four sources: pin, timer, change, converter
// - flags set regardless of masks
// - bit 7 global enable gates all vector requests, not irq
// - enabled flag plus mask vectors core
// - reset clears global enable
// - return pops address, sets global enable
// - core flags live in control byte
// - peripheral flags in separate registers
// - entry clears enable, pushes, loads 0004h
// - pin events vector in three-four cycles
// - only return address is saved
// - entry wins over concurrent enable clear
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module icl_interrupt_control_logic
    import icl_pkg::*;
(
    input  wire logic              clk_sys,      // instruction-cycle clock
    input  wire logic              rst,          // async reset, high
    input  wire icl_pkg::icl_bus_t bus,          // register port request
    output logic [7:0]             rdata,        // read data, cycle after read
    input  wire logic              ext_irq_pin,  // external request pin
    input  wire logic              ext_edge_rise,// 1: rising edge active
    input  wire logic              timer_zero_ovf,// timer overflow pulse
    input  wire logic [3:0]        change_watch_pins, // upper port pins
    input  wire logic              adc_done,     // converter complete pulse
    input  wire logic              return_from_irq, // return instruction executed
    input  wire logic [12:0]       return_pc,    // address to save on entry
    output icl_pkg::icl_vec_t      vec,          // vector request to core
    output logic                   irq           // level event interrupt
);
    import icl_pkg::*;

    logic [7:0] ctl_r;
    logic [7:0] pfa_r, pfb_r, pea_r, peb_r;
    logic [1:0] stat_r, mask_r;
    logic [SYNC_CYCLES-1:0] ext_sync_r;
    logic [3:0] chg_s1_r, chg_s2_r, chg_last_r;
    logic       ext_last_r;
    logic [7:0] rdata_r;
    icl_vec_t   vec_r;
    logic       irq_r;

    function automatic logic wr_at(input icl_bus_t b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // two flops on pins, edge detect and flag stage: 3..4 cycles to the vector
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_sync_r <= '0;
            chg_s1_r   <= 4'h0;
            chg_s2_r   <= 4'h0;
        end else begin
            ext_sync_r <= {ext_sync_r[SYNC_CYCLES-2:0], ext_irq_pin};
            chg_s1_r   <= change_watch_pins;
            chg_s2_r   <= chg_s1_r;
        end
    end

    // last-seen values compared only past the synchronisers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_last_r <= 1'b0;
            chg_last_r <= 4'h0;
        end else begin
            ext_last_r <= ext_sync_r[SYNC_CYCLES-1];
            chg_last_r <= chg_s2_r;
        end
    end

    logic ext_ev, chg_ev, tz_ev;
    assign ext_ev = ext_edge_rise ? (ext_sync_r[SYNC_CYCLES-1] & ~ext_last_r)
                                  : (~ext_sync_r[SYNC_CYCLES-1] & ext_last_r);
    assign chg_ev = |(chg_s2_r ^ chg_last_r);
    assign tz_ev  = timer_zero_ovf;

    logic periph_req, core_req, req, take;
    assign periph_req = ctl_r[CTL_PEIE_BIT] && |((pfa_r & pea_r) | (pfb_r & peb_r));
    assign core_req   = (ctl_r[CTL_TZIE_BIT] && ctl_r[CTL_TZIF_BIT])
                     || (ctl_r[CTL_EXIE_BIT] && ctl_r[CTL_EXIF_BIT])
                     || (ctl_r[CTL_CHIE_BIT] && ctl_r[CTL_CHIF_BIT]);
    assign req  = ctl_r[CTL_GIE_BIT] && (core_req || periph_req);
    // no extra pending stage: it would push pin latency past four cycles
    assign take = req && !vec_r.vector;

    // control byte: flags set win over software clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_r <= CTL_RESET;
        end else begin
            logic [7:0] c;
            c = ctl_r;
            if (wr_at(bus, OFS_CTL)) begin
                c = bus.wdata;
            end
            // an accepted entry overrides a same-cycle clear or set of the enable
            if (take) begin
                c[CTL_GIE_BIT] = 1'b0;
            end else if (return_from_irq) begin
                c[CTL_GIE_BIT] = 1'b1;
            end
            if (take && wr_at(bus, OFS_CTL) && !bus.wdata[CTL_GIE_BIT]) begin
                c[CTL_GIE_BIT] = 1'b0;
            end
            if (tz_ev)  c[CTL_TZIF_BIT] = 1'b1;
            if (ext_ev) c[CTL_EXIF_BIT] = 1'b1;
            if (chg_ev) c[CTL_CHIF_BIT] = 1'b1;
            ctl_r <= c;
        end
    end

    // peripheral flag and enable registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pfa_r <= PF_RESET;
            pfb_r <= PF_RESET;
            pea_r <= PF_RESET;
            peb_r <= PF_RESET;
        end else begin
            logic [7:0] fa;
            fa = pfa_r;
            if (wr_at(bus, OFS_PFA)) fa = bus.wdata & PF_IMPL;
            if (adc_done) fa[PF_ADC_BIT] = 1'b1;
            pfa_r <= fa;
            if (wr_at(bus, OFS_PFB)) pfb_r <= bus.wdata & PF2_IMPL;
            if (wr_at(bus, OFS_PEA)) pea_r <= bus.wdata & PF_IMPL;
            if (wr_at(bus, OFS_PEB)) peb_r <= bus.wdata & PF2_IMPL;
        end
    end

    // vector request: one pulse with push, pc carries the 0004h vector (return_pc is not used here)
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vec_r <= '0;
        end else begin
            vec_r.vector <= take;
            vec_r.push   <= take;
            vec_r.pc     <= take ? IRQ_VECTOR : 13'h0000;
        end
    end

    // sticky entry/return events, write one to clear, set wins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
        end else begin
            logic [1:0] s;
            s = stat_r;
            if (wr_at(bus, OFS_STAT)) s = s & ~bus.wdata[1:0];
            if (take)            s[EV_TAKEN_BIT]  = 1'b1;
            if (return_from_irq) s[EV_RETURN_BIT] = 1'b1;
            stat_r <= s;
            if (wr_at(bus, OFS_MASK)) mask_r <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // read data for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_CTL:  rdata_r <= ctl_r;
                OFS_PFA:  rdata_r <= pfa_r;
                OFS_PFB:  rdata_r <= pfb_r;
                OFS_PEA:  rdata_r <= pea_r;
                OFS_PEB:  rdata_r <= peb_r;
                OFS_STAT: rdata_r <= {6'h00, stat_r};
                OFS_MASK: rdata_r <= {6'h00, mask_r};
                default:  rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign vec   = vec_r;
    assign irq   = irq_r;
endmodule
`default_nettype wire

/* File: verification/icl_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module icl_chk
    import icl_pkg::*;
(
    input wire logic              clk_sys, // clock
    input wire logic              rst,     // reset
    input wire icl_pkg::icl_bus_t bus,     // reg port
    input wire logic [7:0]        rdata,   // read data
    input wire icl_pkg::icl_vec_t vec,     // vector
    input wire logic              irq      // interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_entry;
        vec.vector && vec.push && vec.pc == IRQ_VECTOR;
    endsequence
    chk_vec_entry: assert property (
        vec.vector |-> s_entry ##1 !vec.vector) else $error("bad entry");
    chk_pc_idle: assert property (
        !vec.vector |-> !vec.push && vec.pc == 13'h0000) else $error("pc idle");
    chk_rd_idle: assert property (
        !$past(bus.rd) |-> rdata == 8'h00) else $error("rdata idle");
    chk_unmapped_zero: assert property (
        $past(bus.rd) && $past(bus.addr) > OFS_MASK |-> rdata == 8'h00) else $error("unmapped");
    chk_pfb_zero: assert property (
        $past(bus.rd) && $past(bus.addr) == OFS_PFB |-> rdata == 8'h00) else $error("flags b");
    chk_pfa_bits: assert property (
        $past(bus.rd) && $past(bus.addr) == OFS_PFA |-> (rdata & ~PF_IMPL) == 8'h00) else $error("flags a");
    chk_irq_sticky: assert property (
        $fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2)) else $error("irq fell alone");
    chk_rst_quiet: assert property (
        $fell(rst) |-> !vec.vector && !irq) else $error("out after reset");
endmodule
`default_nettype wire

/* File: verification/icl_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icl_core_model
    import icl_pkg::*;
(
    input wire logic              clk_sys,         // clock
    input wire logic              rst,             // reset
    input wire icl_pkg::icl_vec_t vec,             // vector request
    input wire logic              ret_req,         // bench asks for return
    output logic                  return_from_irq, // return executed
    output logic [12:0]           return_pc,       // saved address
    output logic [3:0]            depth            // stack depth
);
    // a return is issued only if depth is nonzero when ret_req is sampled, like real code
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            return_from_irq <= 1'b0;
            depth           <= 4'h0;
        end else begin
            return_from_irq <= ret_req && depth != 4'h0;
            if (vec.push) depth <= depth + 4'h1;
            else if (return_from_irq) depth <= depth - 4'h1;
        end
    end
    assign return_pc = 13'h0100 + {9'h000, depth};
endmodule
`default_nettype wire

/* File: verification/icl_interrupt_control_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected %0t got %h exp %h", $time, a, b); end end
module icl_interrupt_control_logic_test;
    import icl_pkg::*;
    logic     clk_sys, rst, ext_irq_pin, ext_edge_rise, timer_zero_ovf, adc_done, ret_req, return_from_irq;
    logic [3:0]  change_watch_pins, depth;
    logic [12:0] return_pc;
    logic [7:0]  rdata;
    logic        irq;
    icl_bus_t    bus;
    icl_vec_t    vec;
    int          errors = 0, checks_done = 0, vecs = 0, lat;
    icl_interrupt_control_logic u_icl_interrupt_control_logic (.clk_sys, .rst, .bus, .rdata, .ext_irq_pin,
        .ext_edge_rise, .timer_zero_ovf, .change_watch_pins, .adc_done, .return_from_irq, .return_pc, .vec, .irq);
    icl_core_model u_icl_core_model (.clk_sys, .rst, .vec, .ret_req, .return_from_irq, .return_pc, .depth);
    initial begin clk_sys = 0; forever #50 clk_sys = ~clk_sys; end
    always @(posedge clk_sys) if (vec.vector === 1'b1) vecs++;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        #1 `CHK(rdata, e)
        @(posedge clk_sys);
    endtask
    task automatic ev(input logic tz, input logic ad);
        timer_zero_ovf <= tz;
        adc_done       <= ad;
        @(posedge clk_sys);
        timer_zero_ovf <= 1'b0;
        adc_done       <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst = 1; bus = '0; ext_irq_pin = 0; ext_edge_rise = 1; timer_zero_ovf = 0; adc_done = 0;
        change_watch_pins = 4'h0; ret_req = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(OFS_CTL, CTL_RESET);
        rd(OFS_PFA, PF_RESET);
        rd(4'hF, 8'h00);
        $display("reset test done");
        ev(1'b1, 1'b1);
        rd(OFS_CTL, 8'h04);
        rd(OFS_PFA, 8'h40);
        ext_irq_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(OFS_CTL, 8'h06);
        change_watch_pins <= 4'h8;
        repeat (6) @(posedge clk_sys);
        rd(OFS_CTL, 8'h07);
        `CHK(vecs, 0)
        wr(OFS_CTL, 8'h00);
        rd(OFS_CTL, 8'h00);
        rd(OFS_PFA, 8'h40);
        wr(OFS_PFA, 8'h00);
        $display("flag test done");
        // falling pin with rising select leaves no flag behind
        ext_irq_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wr(OFS_CTL, 8'h90);
        ext_irq_pin <= 1'b1;
        lat = 0;
        do begin @(posedge clk_sys); #1 lat++; end while (vec.vector !== 1'b1 && lat < 10);
        `CHK((lat inside {3, 4}), 1'b1)
        @(posedge clk_sys);
        rd(OFS_CTL, 8'h12);
        wr(OFS_CTL, 8'h10);
        ret_req <= 1'b1;
        @(posedge clk_sys);
        ret_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(OFS_CTL, 8'h90);
        `CHK(depth, 4'h0)
        wr(OFS_PEA, 8'h40);
        wr(OFS_CTL, 8'hC0);
        ev(1'b0, 1'b1);
        #1 `CHK(vecs, 2)
        $display("vector test done");
        wr(OFS_MASK, 8'h03);
        rd(OFS_STAT, 8'h03);
        #1 `CHK(irq, 1'b1)
        wr(OFS_STAT, 8'h01);
        rd(OFS_STAT, 8'h02);
        #1 `CHK(irq, 1'b1)
        wr(OFS_MASK, 8'h01);
        #1 `CHK(irq, 1'b0)
        $display("status test done");
        end_of_test;
    end
    initial begin
        #100us;
        errors++;
        end_of_test;
    end
endmodule
bind icl_interrupt_control_logic icl_chk u_icl_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .vec(vec), .irq(irq));
`default_nettype wire
